// >>> design/nvm_seq_pkg.sv
/*
 * Shared constants and types for the nonvolatile maintenance sequencer:
 * register offsets, field positions, command codes, timing and carriers.
 * Assumes a 40 MHz register clock and a 32-bit APB register bus.
 */
package nvm_seq_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int DW        = 16;        // Stored word width
	localparam int AW        = 5;         // Nonvolatile address width
	localparam int CFG_WORDS = 16;        // Working RAM words
	localparam int QDEPTH    = 4;         // Controller command queue
	localparam int TW        = 28;        // Delay counter width

	localparam logic [AW-1:0] CRC_SLOT = 5'h10;  // Image check word
	localparam logic [AW-1:0] INV_STEP = 5'h1F;  // Invalidate phase
	localparam logic [DW-1:0] ERASED_WORD = 16'hFFFF;
	localparam logic [DW-1:0] CRC_SEED    = 16'hA5C3;
	localparam logic [6:0]    DEFAULT_BASE_ADDR = 7'h5C;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RAM    = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CFG    = 8'h14;

	// Status and configuration bit positions
	localparam int ST_BUSY     = 0;
	localparam int ST_CRC_FAIL = 1;
	localparam int ST_ACCEPT   = 2;
	localparam int ST_REFUSED  = 3;
	localparam int ST_QCOUNT   = 4;
	localparam int CFG_CTRL    = 0;
	localparam int CFG_RAIL_ON = 1;

	// Command codes written to the command register
	localparam logic [2:0] CMD_STORE  = 3'h1;
	localparam logic [2:0] CMD_RELOAD = 3'h2;
	localparam logic [2:0] CMD_WORD   = 3'h3;
	localparam logic [2:0] CMD_ERASE  = 3'h4;
	localparam logic [2:0] CMD_FLOG   = 3'h5;
	localparam logic [2:0] CMD_MATH   = 3'h6;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ      = 40_000_000;
	localparam int STORE_MAX_S = 4;                         // Seconds
	localparam int STORE_MAX_CYCLES = STORE_MAX_S * CLK_HZ;
	// Whole store is invalidate + words + check word, rounded down
	localparam int WORD_PROG_CYCLES = STORE_MAX_CYCLES / (CFG_WORDS + 2);
	localparam int FLOG_CYCLES = 1000;
	localparam int MATH_CYCLES = 64;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		S_LOAD, S_CRC_FAIL, S_IDLE, S_STORE, S_ERASE, S_WORD, S_WORK
	} state_t;

	typedef struct packed {
		logic           pec_req;
		logic           wp;
		logic [6:0]     rsvd;
		logic [6:0]     base_addr;
	} cfg_word_t;

	typedef struct packed {
		logic           en;
		logic [AW-1:0]  addr;
		logic [DW-1:0]  data;
	} nvm_wr_t;

	// Running image check, used by both load and store
	function automatic logic [DW-1:0] crc_step(input logic [DW-1:0] c,
		input logic [DW-1:0] w);
		crc_step = {c[DW-2:0], c[DW-1]} ^ w;
	endfunction

endpackage

// >>> design/nvm_cell_array.sv
/*
 * Nonvolatile word array: keeps its contents through reset, one write
 * port and an asynchronous read port.
 * Assumes the sequencer paces writes; starts erased in simulation.
 */
`timescale 1ns/1ps

module nvm_cell_array (
	input  wire logic                         pclk,
	input  wire logic                         ce,
	input  wire nvm_seq_pkg::nvm_wr_t         wr,
	input  wire logic [nvm_seq_pkg::AW-1:0]   rd_addr,
	output logic [nvm_seq_pkg::DW-1:0]        rd_data
);
	import nvm_seq_pkg::*;

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Factory state is fully erased
	initial begin
		for (int i = 0; i < (1<<AW); i++) begin
			mem[i] = ERASED_WORD;
		end
	end

	// Word programming, not touched by reset
	always_ff @(posedge pclk) begin
		if (ce && wr.en) begin
			mem[wr.addr] <= wr.data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule

// >>> design/nvm_maintenance_sequencer.sv
/*
 * Device-side sequencer for nonvolatile settings: reload at reset,
 * store, direct word programming, erase, fault log and math work,
 * with manager or controller command acceptance, reached over APB.
 * Assumes APB signals synchronous to pclk and one clock domain.
 */
// How it works
// [R1] Reset copies stored image into working RAM
// [R2] Store writes all RAM words to storage
// [R3] Word transfer programs storage directly, bypassing RAM
// [R4] Host refreshes storage about every six months
// [R5] Host programs only below 85 degrees C
// [R6] Bad image check holds device, rails off
// [R7] Store completes within four seconds
// [R8] Host unlocks, erases, programs, verifies, locks
// [R9] Check failure forces default bus address
// [R10] Manager refuses commands during storage or log
// [R11] Controller queues commands; math work is slow
// [R12] Host turns rails off, forces log first
// [R13] Host spaces commands at least 1 ms
// [R14] Host waits 4.1 s after store
// [R15] Host waits 4.1 s after reload
// [R16] Host spaces word writes 4.1 s per byte count
// [R17] Host waits 4.1 s after erase
// [R18] Host flags done and unacknowledged errors
`timescale 1ns/1ps

module nvm_maintenance_sequencer #(
	parameter int word_prog_cycles = nvm_seq_pkg::WORD_PROG_CYCLES,
	parameter int flog_cycles      = nvm_seq_pkg::FLOG_CYCLES,
	parameter int math_cycles      = nvm_seq_pkg::MATH_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             rails_en,
	output logic             busy,
	output logic [6:0]       bus_address,
	output logic             write_protect,
	output logic             pec_required
);
	import nvm_seq_pkg::*;

	state_t                 state;
	logic [AW-1:0]          idx;
	logic [TW-1:0]          timer;
	logic [DW-1:0]          crc_acc;
	logic                   crc_fail;
	logic [DW-1:0]          ram [0:CFG_WORDS-1];
	logic [AW-1:0]          waddr;
	logic [DW-1:0]          wdata;
	logic                   ctrl_type;
	logic                   rail_on;
	logic                   refused;
	logic [2:0]             q [0:QDEPTH-1];
	logic [1:0]             q_wr;
	logic [1:0]             q_rd;
	logic [2:0]             q_cnt;
	nvm_wr_t                nvm_wr;
	logic [AW-1:0]          nvm_rd_addr;
	logic [DW-1:0]          nvm_rd;
	cfg_word_t              cfg0;
	logic                   wr_go;
	logic                   accept;
	logic                   push;
	logic                   pop;
	logic                   idle_like;
	logic                   bad_addr;
	logic [31:0]            next_prdata;

	// ---------------------------------------------------------------
	// Storage array
	// ---------------------------------------------------------------
	nvm_cell_array u_cells (
		.pclk    (pclk),
		.ce      (ce),
		.wr      (nvm_wr),
		.rd_addr (nvm_rd_addr),
		.rd_data (nvm_rd)
	);

	// ---------------------------------------------------------------
	// Bus decode and command acceptance
	// ---------------------------------------------------------------
	assign wr_go     = psel & penable & pready & pwrite;
	assign idle_like = (state == S_IDLE) || (state == S_CRC_FAIL);
	assign cfg0      = cfg_word_t'(ram[0]);
	assign pop       = idle_like && (timer == '0) && (q_cnt != 3'h0);

	// Manager takes a command only when fully idle; controller queues
	always_comb begin
		if (ctrl_type) begin
			accept = (q_cnt != 3'(QDEPTH));        // [R11]
		end else begin
			accept = idle_like && (q_cnt == 3'h0); // [R10]
		end
	end

	assign push = wr_go && (paddr == REG_CMD) && accept &&
		(pwdata[2:0] != 3'h0);

	always_comb begin
		bad_addr = 1'b0;
		if (paddr == REG_CMD) begin
			next_prdata = 32'h0000_0000;
		end else if (paddr == REG_ADDR) begin
			next_prdata = {27'h0, waddr};
		end else if (paddr == REG_WDATA) begin
			next_prdata = {16'h0, wdata};
		end else if (paddr == REG_RAM) begin
			next_prdata = {16'h0, ram[waddr[3:0]]};
		end else if (paddr == REG_STATUS) begin
			next_prdata = 32'h0000_0000;
			next_prdata[ST_BUSY]     = busy;
			next_prdata[ST_CRC_FAIL] = crc_fail;
			next_prdata[ST_ACCEPT]   = accept;
			next_prdata[ST_REFUSED]  = refused;
			next_prdata[ST_QCOUNT+:3] = q_cnt;
		end else if (paddr == REG_CFG) begin
			next_prdata = 32'h0000_0000;
			next_prdata[CFG_CTRL]    = ctrl_type;
			next_prdata[CFG_RAIL_ON] = rail_on;
		end else begin
			next_prdata = 32'h0000_0000;
			bad_addr    = 1'b1;
		end
	end

	// APB answer: one wait state, then ready with registered data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & bad_addr;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	// Software registers; refused flag set wins over its clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waddr     <= '0;
			wdata     <= '0;
			ctrl_type <= 1'b0;
			rail_on   <= 1'b0;
			refused   <= 1'b0;
		end else if (ce) begin
			if (wr_go && paddr == REG_ADDR) begin
				waddr <= pwdata[AW-1:0];
			end
			if (wr_go && paddr == REG_WDATA) begin
				wdata <= pwdata[DW-1:0];
			end
			if (wr_go && paddr == REG_CFG) begin
				ctrl_type <= pwdata[CFG_CTRL];
				rail_on   <= pwdata[CFG_RAIL_ON];
			end
			if (wr_go && (paddr == REG_CMD) && !accept) begin
				refused <= 1'b1;                       // [R10]
			end else if (wr_go && (paddr == REG_RAM) && !idle_like) begin
				refused <= 1'b1;
			end else if (wr_go && paddr == REG_STATUS &&
				pwdata[ST_REFUSED]) begin
				refused <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Command queue
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_wr  <= 2'h0;
			q_rd  <= 2'h0;
			q_cnt <= 3'h0;
		end else if (ce) begin
			if (push) begin
				q_wr <= q_wr + 2'h1;
			end
			if (pop) begin
				q_rd <= q_rd + 2'h1;
			end
			q_cnt <= q_cnt + 3'(push) - 3'(pop);        // [R11]
		end
	end

	// Queue slots hold no control meaning until counted
	always_ff @(posedge pclk) begin
		if (ce && push) begin
			q[q_wr] <= pwdata[2:0];
		end
	end

	// ---------------------------------------------------------------
	// Working RAM: reload from storage or software writes
	// ---------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (state == S_LOAD && timer == '0 && idx < CRC_SLOT) begin
				ram[idx[3:0]] <= nvm_rd;               // [R1]
			end else if (wr_go && paddr == REG_RAM && idle_like) begin
				ram[waddr[3:0]] <= pwdata[DW-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Storage write port
	// ---------------------------------------------------------------
	assign nvm_rd_addr = (state == S_STORE && idx == INV_STEP) ?
		CRC_SLOT : idx;

	always_comb begin
		nvm_wr = '0;
		if (timer == '0) begin
			case (state)
				S_STORE: begin
					nvm_wr.en = 1'b1;
					if (idx == INV_STEP) begin
						nvm_wr.addr = CRC_SLOT;        // Spoil old image first
						nvm_wr.data = ~nvm_rd;
					end else if (idx < CRC_SLOT) begin
						nvm_wr.addr = idx;             // [R2]
						nvm_wr.data = ram[idx[3:0]];
					end else begin
						nvm_wr.addr = CRC_SLOT;
						nvm_wr.data = crc_acc;
					end
				end
				S_ERASE: begin
					nvm_wr.en   = 1'b1;
					nvm_wr.addr = idx;
					nvm_wr.data = ERASED_WORD;
				end
				S_WORD: begin
					nvm_wr.en   = 1'b1;                // [R3]
					nvm_wr.addr = waddr;
					nvm_wr.data = wdata;
				end
				default: begin
					nvm_wr = '0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= S_LOAD;                        // [R1]
			idx      <= '0;
			timer    <= '0;
			crc_acc  <= CRC_SEED;
			crc_fail <= 1'b0;
		end else if (ce) begin
			if (timer != '0) begin
				timer <= timer - 1'b1;
			end else begin
				case (state)
					S_LOAD: begin
						if (idx == CRC_SLOT) begin
							idx      <= '0;
							crc_fail <= (crc_acc != nvm_rd);
							state    <= (crc_acc != nvm_rd) ?
								S_CRC_FAIL : S_IDLE;   // [R6]
						end else begin
							crc_acc <= crc_step(crc_acc, nvm_rd);
							idx     <= idx + 1'b1;
						end
					end
					S_IDLE, S_CRC_FAIL: begin
						if (pop) begin
							crc_acc <= CRC_SEED;
							case (q[q_rd])
								CMD_STORE: begin
									idx   <= INV_STEP;
									state <= S_STORE;
								end
								CMD_RELOAD: begin
									idx   <= '0;
									state <= S_LOAD;
								end
								CMD_WORD: state <= S_WORD;
								CMD_ERASE: begin
									idx   <= '0;
									state <= S_ERASE;
								end
								CMD_FLOG: begin
									if (!crc_fail) begin
										timer <= TW'(flog_cycles);
										state <= S_WORK;
									end
								end
								CMD_MATH: begin
									if (ctrl_type && !crc_fail) begin
										timer <= TW'(math_cycles); // [R11]
										state <= S_WORK;
									end
								end
								default: state <= state;
							endcase
						end
					end
					S_STORE: begin
						timer <= TW'(word_prog_cycles);  // [R7]
						if (idx == INV_STEP) begin
							idx <= '0;
						end else if (idx < CRC_SLOT) begin
							crc_acc <= crc_step(crc_acc, ram[idx[3:0]]);
							idx     <= idx + 1'b1;
						end else begin
							state <= S_WORK;
						end
					end
					S_ERASE: begin
						timer <= TW'(word_prog_cycles);
						if (idx == CRC_SLOT) begin
							state <= S_WORK;
						end else begin
							idx <= idx + 1'b1;
						end
					end
					S_WORD: begin
						timer <= TW'(word_prog_cycles);  // [R3]
						state <= S_WORK;
					end
					default: begin
						state <= crc_fail ? S_CRC_FAIL : S_IDLE;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Registered device outputs
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rails_en      <= 1'b0;
			busy          <= 1'b1;
			bus_address   <= DEFAULT_BASE_ADDR;
			write_protect <= 1'b0;
			pec_required  <= 1'b0;
		end else if (ce) begin
			rails_en <= (state == S_IDLE) && rail_on && !crc_fail; // [R6]
			busy     <= !idle_like || (q_cnt != 3'h0);             // [R10]
			if (crc_fail || state == S_LOAD) begin
				bus_address <= DEFAULT_BASE_ADDR;                  // [R9]
			end else begin
				bus_address <= cfg0.base_addr;
			end
			write_protect <= cfg0.wp;             // Unvalidated after failure
			pec_required  <= cfg0.pec_req;        // Unvalidated after failure; [R9] forces only the bus address
		end
	end

endmodule

// >>> tb/nvm_seq_checker.sv
/*
 * Checker: bus timing, load after reset, busy and address relations.
 * Assumes ce is held high and presetn is asynchronous, active low.
 */
`timescale 1ns/1ps

module nvm_seq_checker
	import nvm_seq_pkg::*;
#(
	parameter int word_prog_cycles = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rails_en,
	input wire logic        busy,
	input wire logic [6:0]  bus_address
);
	localparam int LIM = 18 * (word_prog_cycles + 2) + 32;
	int   busy_cnt;
	logic cmd_go;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Length of the current busy stretch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt <= 0;
		else
			busy_cnt <= busy ? busy_cnt + 1 : 0;
	end

	// Storage command write completing on the bus, idle or not
	assign cmd_go = psel && penable && pready && pwrite && paddr == REG_CMD
		&& pwdata[2:0] inside {CMD_STORE, CMD_RELOAD, CMD_WORD, CMD_ERASE};

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_one_wait;
		psel && !penable ##1 psel && penable |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("access not answered after one wait state");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready held too long");
	property p_ready_access;
		pready |-> psel && penable;
	endproperty
	a_ready_access: assert property (p_ready_access)
		else $error("pready outside access phase");
	property p_err_map;
		pready && paddr inside {[REG_CMD:REG_CFG]} |-> !pslverr;
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("error on mapped register");
	property p_load_busy;
		$rose(presetn) |-> busy [*8];
	endproperty
	a_load_busy: assert property (p_load_busy)
		else $error("busy dropped during load");
	property p_load_addr;
		$rose(presetn) |-> bus_address == DEFAULT_BASE_ADDR && !rails_en;
	endproperty
	a_load_addr: assert property (p_load_addr)
		else $error("address or rails wrong at load");
	property p_busy_lim;
		busy_cnt <= LIM;
	endproperty
	a_busy_lim: assert property (p_busy_lim)
		else $error("busy stretch too long");
	property p_cmd_busy;
		cmd_go && !busy |-> ##[1:3] busy;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy)
		else $error("command did not start");
endmodule

bind nvm_maintenance_sequencer nvm_seq_checker #(
	.word_prog_cycles(word_prog_cycles)
) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .rails_en(rails_en), .busy(busy),
	.bus_address(bus_address));

// >>> tb/bus_host_model.sv
/*
 * Host model: APB master spacing transfers by gap clocks only.
 * Assumes pclk from the bench; tasks start just after a rising edge.
 */
`timescale 1ns/1ps

module bus_host_model #(
	parameter int gap = 1
) (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	int hangs = 0;

	// Idle bus
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h0;
	end

	// One transfer, held until pready is sampled high or 16 clocks pass
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
			hangs++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;                  // No stale data once released
		repeat (gap) @(posedge pclk);
	endtask
endmodule

// >>> tb/tb_nvm_maintenance_sequencer.sv
/*
 * Bench: register sequences through the host model, with checks.
 * Assumes shortened timing parameters and ce held high.
 */
`timescale 1ns/1ps

module tb_nvm_maintenance_sequencer;
	import nvm_seq_pkg::*;
	localparam int WPC = 4;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic        rails_en, busy, write_protect, pec_required;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0]  bus_address;
	int          errors = 0;
	int          n_checks = 0;
	int          cyc;

	nvm_maintenance_sequencer #(.word_prog_cycles(WPC), .flog_cycles(8),
		.math_cycles(4)) i_dut (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rails_en(rails_en),
		.busy(busy), .bus_address(bus_address),
		.write_protect(write_protect), .pec_required(pec_required));
	bus_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 40 MHz clock
	initial begin
		forever #12.5 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		errors += i_host.hangs;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		i_host.xfer(w, a, d, rd, err);
		if (i_host.hangs != 0)
			tally_and_finish;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdm(logic [7:0] a, logic [31:0] m, logic [31:0] e,
		string n);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd & m);
	endtask
	// Polls busy in place of the long host delays
	task automatic wait_idle;
		cyc = 0;
		repeat (3) @(posedge pclk);
		while (busy !== 1'b0 && cyc < 2000) begin
			@(posedge pclk);
			cyc++;
		end
		if (busy !== 1'b0) begin
			errors++;
			tally_and_finish;
		end
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle;
		rdm(REG_STATUS, 32'h3, 32'h2, "crc_fail");
		chk("rails_en", 32'h0, 32'(rails_en));
		chk("bus_address", 32'h5C, 32'(bus_address));
		bus(1'b0, 8'h18, 32'h0);
		chk("pslverr", 32'h1, 32'(err));
		for (int i = 0; i < 16; i++) begin
			wr(REG_ADDR, i);
			wr(REG_RAM, i ? 32'h1100 + i : 32'h8021);
		end
		wr(REG_CFG, 32'h2);
		// Die temperature taken as below the limit here
		wr(REG_CMD, 32'(CMD_STORE));
		wait_idle;
		chk("store_time", 32'h1, 32'(cyc <= 18 * (WPC + 2) + 8));
		wr(REG_CMD, 32'(CMD_RELOAD));
		wait_idle;
		rdm(REG_STATUS, 32'h2, 32'h0, "crc_ok");
		chk("bus_address", 32'h21, 32'(bus_address));
		chk("pec", 32'h1, 32'(pec_required));
		chk("wp", 32'h0, 32'(write_protect));
		wr(REG_ADDR, 5);
		rdm(REG_RAM, 32'hFFFF, 32'h1105, "ram5");
		// Manager refuses while logging
		wr(REG_CMD, 32'(CMD_FLOG));
		wr(REG_CMD, 32'(CMD_STORE));
		rdm(REG_STATUS, 32'h8, 32'h8, "refused");
		wait_idle;
		wr(REG_STATUS, 32'h8);
		rdm(REG_STATUS, 32'h8, 32'h0, "refused_clr");
		// Controller queues slow work
		wr(REG_CFG, 32'h3);
		for (int i = 0; i < 3; i++)
			wr(REG_CMD, 32'(CMD_MATH));
		rdm(REG_STATUS, 32'h8, 32'h0, "queued");
		wait_idle;
		// Direct word write bypasses RAM
		wr(REG_ADDR, 3);
		wr(REG_WDATA, 32'hBEEF);
		wr(REG_CMD, 32'(CMD_WORD));
		wait_idle;
		rdm(REG_RAM, 32'hFFFF, 32'h1103, "ram_bypass");
		wr(REG_CMD, 32'(CMD_RELOAD));
		wait_idle;
		rdm(REG_RAM, 32'hFFFF, 32'hBEEF, "ram_reload");
		rdm(REG_STATUS, 32'h2, 32'h2, "crc_bad");
		chk("rails_en", 32'h0, 32'(rails_en));
		chk("bus_address", 32'h5C, 32'(bus_address));
		// Erase, then reset after it completes
		wr(REG_CMD, 32'(CMD_ERASE));
		wait_idle;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle;
		wr(REG_ADDR, 3);
		rdm(REG_RAM, 32'hFFFF, 32'hFFFF, "ram_erased");
		tally_and_finish;
	end
endmodule
